// file: design/srsr_regs.sv
module srsr_regs (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_SCL,
    input  wire logic        I_SDA,
    input  wire logic        I_ADDR_SEL,
    input  wire logic        I_TEMP_DONE,
    input  wire logic [13:0] I_TEMP_VALUE,
    input  wire logic        I_HUM_DONE,
    input  wire logic [13:0] I_HUM_VALUE,
    output logic             O_SDA_OUT,
    output logic             O_SDA_OE,
    output logic             O_EVENT_PIN,
    output logic [7:0]       O_CONV_SETUP,
    output logic [7:0]       O_TEMP_TRIM,
    output logic [7:0]       O_HUM_TRIM,
    output logic             O_AUTO_MODE,
    output logic             O_SOFT_RESET
);
    // ------------------------------------------------------------
    // Serial front end
    // ------------------------------------------------------------
    logic [7:0] rx_byte, tx_q, tx_d, ptr_q, ptr_d, rd_byte;
    logic       rx_ptr, rx_stb, tx_req, ack;

    srsr_i2c_port u_port (
        .i_clk      (I_CLK),
        .i_rst      (I_RST),
        .i_scl      (I_SCL),
        .i_sda      (I_SDA),
        .i_addr_sel (I_ADDR_SEL),
        .i_ack      (ack),
        .i_tx_byte  (tx_q),
        .o_sda_oe   (O_SDA_OE),
        .o_rx_byte  (rx_byte),
        .o_rx_ptr   (rx_ptr),
        .o_rx_stb   (rx_stb),
        .o_tx_req   (tx_req)
    );
    assign O_SDA_OUT = 1'b0;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] temp_q, temp_d, hum_q, hum_d;
    logic [7:0]  stat_q, stat_d, peak_t_q, peak_t_d, peak_h_q, peak_h_d;
    logic [7:0]  en_q, en_d, trim_t_q, trim_t_d, trim_h_q, trim_h_d;
    logic [7:0]  tlo_q, tlo_d, thi_q, thi_d, hlo_q, hlo_d, hhi_q, hhi_d;
    logic [7:0]  cfg_q, cfg_d, setup_q, setup_d;
    logic        soft_q, soft_d, pin_q, pin_d;
    logic        ptr_ok, wr_ok, stat_rd, res_rd, auto, mode, pin_act;
    logic [7:0]  t8, h8;

    function automatic logic flag_next(input logic q, input logic upd, input logic cmp,
                                       input logic comp_mode, input logic clr);
        // Latched: a new hit beats a clearing read
        if (upd && (cmp || comp_mode)) begin
            return cmp;
        end else if (clr) begin
            return 1'b0;
        end
        return q;
    endfunction

    assign ptr_ok = (rx_byte <= srsr_pkg::A_SETUP) || (rx_byte >= srsr_pkg::A_MAKER_LO);
    // Status writes are acknowledged but change nothing
    assign wr_ok  = (ptr_q >= srsr_pkg::A_STATUS) && (ptr_q <= srsr_pkg::A_SETUP);
    assign ack    = rx_ptr ? ptr_ok : wr_ok;
    assign stat_rd = tx_req && (ptr_q == srsr_pkg::A_STATUS);
    assign res_rd  = tx_req && (ptr_q <= srsr_pkg::A_HUM_HI);
    assign auto    = |cfg_q[srsr_pkg::B_AUTO_HI:srsr_pkg::B_AUTO_LO];
    assign mode    = cfg_q[srsr_pkg::B_MODE];
    assign t8      = I_TEMP_VALUE[13:6];
    assign h8      = I_HUM_VALUE[13:6];
    assign pin_act = |(stat_q & en_q & srsr_pkg::STATUS_MASK);

    always_comb begin
        if (ptr_q == srsr_pkg::A_TEMP_LO) begin
            rd_byte = temp_q[7:0];
        end else if (ptr_q == srsr_pkg::A_TEMP_HI) begin
            rd_byte = temp_q[15:8];
        end else if (ptr_q == srsr_pkg::A_HUM_LO) begin
            rd_byte = hum_q[7:0];
        end else if (ptr_q == srsr_pkg::A_HUM_HI) begin
            rd_byte = hum_q[15:8];
        end else if (ptr_q == srsr_pkg::A_STATUS) begin
            rd_byte = stat_q & srsr_pkg::STATUS_MASK;
        end else if (ptr_q == srsr_pkg::A_PEAK_T) begin
            rd_byte = peak_t_q;
        end else if (ptr_q == srsr_pkg::A_PEAK_H) begin
            rd_byte = peak_h_q;
        end else if (ptr_q == srsr_pkg::A_ENABLE) begin
            rd_byte = en_q;
        end else if (ptr_q == srsr_pkg::A_TRIM_T) begin
            rd_byte = trim_t_q;
        end else if (ptr_q == srsr_pkg::A_TRIM_H) begin
            rd_byte = trim_h_q;
        end else if (ptr_q == srsr_pkg::A_TLIM_LO) begin
            rd_byte = tlo_q;
        end else if (ptr_q == srsr_pkg::A_TLIM_HI) begin
            rd_byte = thi_q;
        end else if (ptr_q == srsr_pkg::A_HLIM_LO) begin
            rd_byte = hlo_q;
        end else if (ptr_q == srsr_pkg::A_HLIM_HI) begin
            rd_byte = hhi_q;
        end else if (ptr_q == srsr_pkg::A_PIN_CFG) begin
            rd_byte = cfg_q;
        end else if (ptr_q == srsr_pkg::A_SETUP) begin
            rd_byte = setup_q;
        end else if (ptr_q == srsr_pkg::A_MAKER_LO) begin
            rd_byte = srsr_pkg::MAKER_LO;
        end else if (ptr_q == srsr_pkg::A_MAKER_HI) begin
            rd_byte = srsr_pkg::MAKER_HI;
        end else if (ptr_q == srsr_pkg::A_PART_LO) begin
            rd_byte = srsr_pkg::PART_LO;
        end else if (ptr_q == srsr_pkg::A_PART_HI) begin
            rd_byte = srsr_pkg::PART_HI;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        temp_d   = temp_q;
        hum_d    = hum_q;
        stat_d   = stat_q;
        peak_t_d = peak_t_q;
        peak_h_d = peak_h_q;
        en_d     = en_q;
        trim_t_d = trim_t_q;
        trim_h_d = trim_h_q;
        tlo_d    = tlo_q;
        thi_d    = thi_q;
        hlo_d    = hlo_q;
        hhi_d    = hhi_q;
        cfg_d    = cfg_q;
        setup_d  = setup_q;
        ptr_d    = ptr_q;
        tx_d     = tx_q;
        soft_d   = 1'b0;
        // Event pin: inactive level when the pin is disabled
        pin_d = cfg_q[srsr_pkg::B_POL] ~^ (pin_act & cfg_q[srsr_pkg::B_PIN_EN]);
        if (soft_q) begin
            // Soft reset restores every register, pointer kept
            temp_d   = 16'h0000;
            hum_d    = 16'h0000;
            stat_d   = srsr_pkg::RST_ZERO;
            peak_t_d = srsr_pkg::RST_ZERO;
            peak_h_d = srsr_pkg::RST_ZERO;
            en_d     = srsr_pkg::RST_ZERO;
            trim_t_d = srsr_pkg::RST_ZERO;
            trim_h_d = srsr_pkg::RST_ZERO;
            tlo_d    = srsr_pkg::RST_ZERO;
            thi_d    = srsr_pkg::RST_TLIM_HI;
            hlo_d    = srsr_pkg::RST_ZERO;
            hhi_d    = srsr_pkg::RST_HLIM_HI;
            cfg_d    = srsr_pkg::RST_ZERO;
            setup_d  = srsr_pkg::RST_ZERO;
        end else begin
            // Host scales results per degC/%RH formulas
            if (I_TEMP_DONE) begin
                temp_d = {I_TEMP_VALUE, 2'b00};
            end
            if (I_HUM_DONE) begin
                hum_d = {I_HUM_VALUE, 2'b00};
            end
            // Set beats the clearing read
            if (I_TEMP_DONE || I_HUM_DONE) begin
                stat_d[srsr_pkg::B_READY] = 1'b1;
            end else if (stat_rd || res_rd) begin
                stat_d[srsr_pkg::B_READY] = 1'b0;
            end
            stat_d[srsr_pkg::B_T_UP] = flag_next(stat_q[srsr_pkg::B_T_UP], I_TEMP_DONE,
                                                 en_q[srsr_pkg::B_T_UP] && (t8 > thi_q), mode, stat_rd);
            stat_d[srsr_pkg::B_T_LO] = flag_next(stat_q[srsr_pkg::B_T_LO], I_TEMP_DONE,
                                                 en_q[srsr_pkg::B_T_LO] && (t8 < tlo_q), mode, stat_rd);
            stat_d[srsr_pkg::B_H_UP] = flag_next(stat_q[srsr_pkg::B_H_UP], I_HUM_DONE,
                                                 en_q[srsr_pkg::B_H_UP] && (h8 > hhi_q), mode, stat_rd);
            stat_d[srsr_pkg::B_H_LO] = flag_next(stat_q[srsr_pkg::B_H_LO], I_HUM_DONE,
                                                 en_q[srsr_pkg::B_H_LO] && (h8 < hlo_q), mode, stat_rd);
            stat_d[2:0] = 3'b000;
            if (!auto && I_TEMP_DONE && t8 > peak_t_q) begin
                peak_t_d = t8;
            end
            if (!auto && I_HUM_DONE && h8 > peak_h_q) begin
                peak_h_d = h8;
            end
            if (rx_stb && rx_ptr && ptr_ok) begin
                ptr_d = rx_byte;
            end else if (rx_stb && !rx_ptr) begin
                ptr_d = ptr_q + 8'h01;
                if (ptr_q == srsr_pkg::A_PEAK_T) begin
                    peak_t_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_PEAK_H) begin
                    peak_h_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_ENABLE) begin
                    en_d = rx_byte & srsr_pkg::STATUS_MASK;
                end else if (ptr_q == srsr_pkg::A_TRIM_T) begin
                    trim_t_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_TRIM_H) begin
                    trim_h_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_TLIM_LO) begin
                    tlo_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_TLIM_HI) begin
                    thi_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_HLIM_LO) begin
                    hlo_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_HLIM_HI) begin
                    hhi_d = rx_byte;
                end else if (ptr_q == srsr_pkg::A_PIN_CFG) begin
                    cfg_d  = rx_byte & ~(8'h01 << srsr_pkg::B_SOFT);
                    soft_d = rx_byte[srsr_pkg::B_SOFT];
                end else if (ptr_q == srsr_pkg::A_SETUP) begin
                    setup_d = rx_byte;
                end
            end
            if (tx_req) begin
                tx_d  = rd_byte;
                ptr_d = ptr_q + 8'h01;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            temp_q   <= 16'h0000;
            hum_q    <= 16'h0000;
            stat_q   <= srsr_pkg::RST_ZERO;
            peak_t_q <= srsr_pkg::RST_ZERO;
            peak_h_q <= srsr_pkg::RST_ZERO;
            en_q     <= srsr_pkg::RST_ZERO;
            trim_t_q <= srsr_pkg::RST_ZERO;
            trim_h_q <= srsr_pkg::RST_ZERO;
            tlo_q    <= srsr_pkg::RST_ZERO;
            thi_q    <= srsr_pkg::RST_TLIM_HI;
            hlo_q    <= srsr_pkg::RST_ZERO;
            hhi_q    <= srsr_pkg::RST_HLIM_HI;
            cfg_q    <= srsr_pkg::RST_ZERO;
            setup_q  <= srsr_pkg::RST_ZERO;
            ptr_q    <= 8'h00;
            tx_q     <= 8'h00;
            soft_q   <= 1'b0;
            pin_q    <= 1'b1;
        end else begin
            temp_q   <= temp_d;
            hum_q    <= hum_d;
            stat_q   <= stat_d;
            peak_t_q <= peak_t_d;
            peak_h_q <= peak_h_d;
            en_q     <= en_d;
            trim_t_q <= trim_t_d;
            trim_h_q <= trim_h_d;
            tlo_q    <= tlo_d;
            thi_q    <= thi_d;
            hlo_q    <= hlo_d;
            hhi_q    <= hhi_d;
            cfg_q    <= cfg_d;
            setup_q  <= setup_d;
            ptr_q    <= ptr_d;
            tx_q     <= tx_d;
            soft_q   <= soft_d;
            pin_q    <= pin_d;
        end
    end

    assign O_EVENT_PIN  = pin_q;
    assign O_CONV_SETUP = setup_q;
    assign O_TEMP_TRIM  = trim_t_q;
    assign O_HUM_TRIM   = trim_h_q;
    assign O_AUTO_MODE  = auto;
    assign O_SOFT_RESET = soft_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    temp_lsbs_a: assert property (temp_q[1:0] == 2'b00 && hum_q[1:0] == 2'b00)
        else $error("result low bits not zero");
    temp_load_a: assert property (I_TEMP_DONE && !soft_q |=> temp_q[15:2] == $past(I_TEMP_VALUE))
        else $error("temperature result not loaded");
    stat_res_a: assert property (stat_q[2:0] == 3'b000)
        else $error("reserved status bits set");
    ready_set_a: assert property ((I_TEMP_DONE || I_HUM_DONE) && !soft_q |=> stat_q[7])
        else $error("data ready not set");
    ready_clr_a: assert property (res_rd && !I_TEMP_DONE && !I_HUM_DONE |=> !stat_q[7])
        else $error("data ready not cleared on read");
    latch_hold_a: assert property (!mode && stat_q[6] && !stat_rd && !soft_q |=> stat_q[6])
        else $error("latched flag dropped");
    peak_auto_a: assert property (auto && !rx_stb && !soft_q |=> $stable(peak_t_q) && $stable(peak_h_q))
        else $error("peak updated in auto mode");
    ptr_inc_a: assert property (tx_req && !soft_q |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer not incremented");
    bad_ptr_a: assert property (rx_stb && rx_ptr && !ptr_ok |-> !ack ##1 ptr_q == $past(ptr_q))
        else $error("unused pointer accepted");
    pin_pol_a: assert property (##1 O_EVENT_PIN == ($past(cfg_q[1]) ~^ ($past(pin_act) && $past(cfg_q[2]))))
        else $error("event pin level wrong");
endmodule

// file: design/srsr_pkg.sv
package srsr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_TEMP_LO  = 8'h00;
    localparam logic [7:0] A_TEMP_HI  = 8'h01;
    localparam logic [7:0] A_HUM_LO   = 8'h02;
    localparam logic [7:0] A_HUM_HI   = 8'h03;
    localparam logic [7:0] A_STATUS   = 8'h04;
    localparam logic [7:0] A_PEAK_T   = 8'h05;
    localparam logic [7:0] A_PEAK_H   = 8'h06;
    localparam logic [7:0] A_ENABLE   = 8'h07;
    localparam logic [7:0] A_TRIM_T   = 8'h08;
    localparam logic [7:0] A_TRIM_H   = 8'h09;
    localparam logic [7:0] A_TLIM_LO  = 8'h0A;
    localparam logic [7:0] A_TLIM_HI  = 8'h0B;
    localparam logic [7:0] A_HLIM_LO  = 8'h0C;
    localparam logic [7:0] A_HLIM_HI  = 8'h0D;
    localparam logic [7:0] A_PIN_CFG  = 8'h0E;
    localparam logic [7:0] A_SETUP    = 8'h0F;
    localparam logic [7:0] A_MAKER_LO = 8'hFC;
    localparam logic [7:0] A_MAKER_HI = 8'hFD;
    localparam logic [7:0] A_PART_LO  = 8'hFE;
    localparam logic [7:0] A_PART_HI  = 8'hFF;
    // ------------------------------------------------------------
    // Reset values and identity (identity values are arbitrary)
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_TLIM_HI = 8'h7F;
    localparam logic [7:0] RST_HLIM_HI = 8'hFF;
    localparam logic [7:0] MAKER_LO    = 8'h5A;
    localparam logic [7:0] MAKER_HI    = 8'hA5;
    localparam logic [7:0] PART_LO     = 8'h3C;
    localparam logic [7:0] PART_HI     = 8'hC3;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_READY   = 7;
    localparam int B_T_UP    = 6;
    localparam int B_T_LO    = 5;
    localparam int B_H_UP    = 4;
    localparam int B_H_LO    = 3;
    localparam int B_SOFT    = 7;
    localparam int B_AUTO_HI = 6;
    localparam int B_AUTO_LO = 4;
    localparam int B_PIN_EN  = 2;
    localparam int B_POL     = 1;
    localparam int B_MODE    = 0;
    localparam logic [7:0] STATUS_MASK = 8'hF8;
    // Host scaling: degC = raw/2^16*165-40, %RH = raw/2^16*100
    localparam int TEMP_SPAN   = 165;
    localparam int TEMP_OFFSET = 40;
    localparam int HUM_SPAN    = 100;
    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    localparam logic [5:0] DEV_ADDR_TOP = 6'h20;
    localparam logic [3:0] BITS_BYTE    = 4'h8;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TXLD, S_TX, S_MACK} srsr_state_t;
    typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} srsr_kind_t;
endpackage

// file: design/srsr_i2c_port.sv
module srsr_i2c_port (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_addr_sel,
    input  wire logic       i_ack,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_sda_oe,
    output logic [7:0]      o_rx_byte,
    output logic            o_rx_ptr,
    output logic            o_rx_stb,
    output logic            o_tx_req
);
    srsr_pkg::srsr_state_t st_q, st_d;
    srsr_pkg::srsr_kind_t  kind_q, kind_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic       scl_q, sda_q, rd_q, rd_d, ack_q, ack_d;
    logic       rise, fall, start, stop, byte_end;

    assign rise     = i_scl & ~scl_q;
    assign fall     = ~i_scl & scl_q;
    assign start    = scl_q & i_scl & sda_q & ~i_sda;
    assign stop     = scl_q & i_scl & ~sda_q & i_sda;
    assign byte_end = (st_q == srsr_pkg::S_RX) && fall && (cnt_q == srsr_pkg::BITS_BYTE);
    assign o_rx_byte = sh_q;
    assign o_rx_ptr  = (kind_q == srsr_pkg::K_PTR);
    assign o_rx_stb  = byte_end && (kind_q != srsr_pkg::K_ADDR);
    assign o_tx_req  = (st_q == srsr_pkg::S_ACK && fall && ack_q && rd_q && kind_q == srsr_pkg::K_ADDR) ||
                       (st_q == srsr_pkg::S_MACK && fall && ack_q);
    assign o_sda_oe  = (st_q == srsr_pkg::S_ACK && ack_q) || (st_q == srsr_pkg::S_TX && !sh_q[7]);

    always_comb begin
        st_d   = st_q;
        kind_d = kind_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        rd_d   = rd_q;
        ack_d  = ack_q;
        if (start) begin
            st_d   = srsr_pkg::S_RX;
            kind_d = srsr_pkg::K_ADDR;
            cnt_d  = 4'h0;
        end else if (stop) begin
            st_d = srsr_pkg::S_IDLE;
        end else begin
            case (st_q)
                srsr_pkg::S_RX: begin
                    if (rise && cnt_q != srsr_pkg::BITS_BYTE) begin
                        sh_d  = {sh_q[6:0], i_sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (byte_end) begin
                        st_d = srsr_pkg::S_ACK;
                        if (kind_q == srsr_pkg::K_ADDR) begin
                            ack_d = (sh_q[7:1] == {srsr_pkg::DEV_ADDR_TOP, i_addr_sel});
                            rd_d  = sh_q[0];
                        end else begin
                            ack_d = i_ack;
                        end
                    end
                end
                srsr_pkg::S_ACK: begin
                    if (fall) begin
                        cnt_d = 4'h0;
                        if (!ack_q) begin
                            st_d = srsr_pkg::S_IDLE;
                        end else if (rd_q && kind_q == srsr_pkg::K_ADDR) begin
                            st_d = srsr_pkg::S_TXLD;
                        end else begin
                            st_d   = srsr_pkg::S_RX;
                            kind_d = (kind_q == srsr_pkg::K_ADDR) ? srsr_pkg::K_PTR : srsr_pkg::K_DATA;
                        end
                    end
                end
                srsr_pkg::S_TXLD: begin
                    sh_d = i_tx_byte;
                    st_d = srsr_pkg::S_TX;
                end
                srsr_pkg::S_TX: begin
                    if (fall) begin
                        sh_d  = {sh_q[6:0], 1'b1};
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == srsr_pkg::BITS_BYTE - 4'h1) begin
                            st_d = srsr_pkg::S_MACK;
                        end
                    end
                end
                srsr_pkg::S_MACK: begin
                    if (rise) begin
                        ack_d = ~i_sda;
                    end else if (fall) begin
                        st_d  = ack_q ? srsr_pkg::S_TXLD : srsr_pkg::S_IDLE;
                        cnt_d = 4'h0;
                    end
                end
                default: st_d = srsr_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q   <= srsr_pkg::S_IDLE;
            kind_q <= srsr_pkg::K_ADDR;
            sh_q   <= 8'h00;
            cnt_q  <= 4'h0;
            rd_q   <= 1'b0;
            ack_q  <= 1'b0;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            st_q   <= st_d;
            kind_q <= kind_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            rd_q   <= rd_d;
            ack_q  <= ack_d;
            scl_q  <= i_scl;
            sda_q  <= i_sda;
        end
    end
endmodule

// file: bench/srsr_host.sv
// ----
// Serial host; data bits change SDA only while SCL is low, start and stop change it while SCL is high
// ----
module srsr_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Also serves as repeated start
    task automatic start();
        o_sda_oe <= 1'b0;
        tk(5);
        o_scl <= 1'b1;
        tk(5);
        o_sda_oe <= 1'b1;
        tk(5);
        o_scl <= 1'b0;
        tk(2);
    endtask
    task automatic stop();
        o_sda_oe <= 1'b1;
        tk(5);
        o_scl <= 1'b1;
        tk(5);
        o_sda_oe <= 1'b0;
        tk(5);
    endtask
    // Nine clocks; a 1 in d releases the line so the device can answer
    task automatic xb(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            o_sda_oe <= ~d[i];
            tk(5);
            o_scl <= 1'b1;
            tk(5);
            q[i] = i_sda;
            o_scl <= 1'b0;
            tk(2);
        end
    endtask
endmodule

// file: bench/tb.sv
// ----
// Register bank bench
// ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst, scl, hoe, doe, pin, sda, td, hd, ak, auto, srst;
    logic       soft_seen = 1'b0;
    logic [7:0]  ttrim, htrim, setup;
    logic [13:0] tv, hv;
    logic [8:0]  q;
    logic [7:0]  rv [16];
    logic [7:0]  ex [7] = '{8'hF0, 8'hEA, 8'hD0, 8'h48, 8'h00, 8'hEA, 8'h48};
    int          n_mismatch = 0, check_count = 0;
    // Open drain with pull-up
    assign sda = ~(hoe | doe);
    srsr_host host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(hoe));
    srsr_regs dut_u (.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .I_ADDR_SEL(1'b0), .I_TEMP_DONE(td),
        .I_TEMP_VALUE(tv), .I_HUM_DONE(hd), .I_HUM_VALUE(hv), .O_SDA_OUT(), .O_SDA_OE(doe), .O_EVENT_PIN(pin),
        .O_CONV_SETUP(setup), .O_TEMP_TRIM(ttrim), .O_HUM_TRIM(htrim), .O_AUTO_MODE(auto), .O_SOFT_RESET(srst));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Soft reset is a one-cycle pulse, so keep a sticky copy
    always @(posedge clk) if (srst) soft_seen <= 1'b1;
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host_u.start();
        host_u.xb({8'h80, 1'b1}, q);
        host_u.xb({p, 1'b1}, q);
        ak = ~q[0];
        if (ak) begin
            host_u.xb({d, 1'b1}, q);
            ak = ~q[0];
        end
        host_u.stop();
    endtask
    task automatic wr2(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
        host_u.start();
        host_u.xb({8'h80, 1'b1}, q);
        host_u.xb({p, 1'b1}, q);
        host_u.xb({d0, 1'b1}, q);
        host_u.xb({d1, 1'b1}, q);
        host_u.stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        host_u.start();
        host_u.xb({8'h80, 1'b1}, q);
        host_u.xb({p, 1'b1}, q);
        host_u.start();
        host_u.xb({8'h81, 1'b1}, q);
        for (int i = 0; i < n; i++) begin
            host_u.xb({8'hFF, i == n - 1}, q);
            rv[i] = q[8:1];
        end
        host_u.stop();
    endtask
    task automatic conv(input logic [13:0] t, input logic [13:0] h);
        td <= 1'b1;
        hd <= 1'b1;
        tv <= t;
        hv <= h;
        host_u.tk(1);
        td <= 1'b0;
        hd <= 1'b0;
        host_u.tk(3);
    endtask
    initial begin
        rst = 1'b1;
        {td, hd, tv, hv} = '0;
        host_u.tk(10);
        rst <= 1'b0;
        host_u.tk(2);
        chk("pin", {7'h00, pin}, 8'h01);
        chk("srst", {7'h00, soft_seen}, 8'h00);
        rd(8'h00, 16);
        for (int i = 0; i < 16; i++) chk("rst", rv[i], i == 11 ? 8'h7F : i == 13 ? 8'hFF : 8'h00);
        conv(14'h3ABC, 14'h1234);
        rd(8'h00, 7);
        for (int i = 0; i < 7; i++) chk("res", rv[i], ex[i]);
        wr(8'h0E, 8'h10);
        chk("auto", {7'h00, auto}, 8'h01);
        conv(14'h3FC0, 14'h3FC0);
        rd(8'h04, 3);
        chk("st", rv[0], 8'h80);
        chk("pk", rv[1], 8'hEA);
        chk("pk", rv[2], 8'h48);
        wr(8'h07, 8'h40);
        wr(8'h0E, 8'h06);
        conv(14'h3FC0, 14'h0000);
        chk("pin", {7'h00, pin}, 8'h01);
        conv(14'h0000, 14'h0000);
        rd(8'h04, 1);
        chk("st", rv[0], 8'hC0);
        chk("pin", {7'h00, pin}, 8'h00);
        wr(8'h0E, 8'h07);
        conv(14'h3FC0, 14'h0000);
        chk("pin", {7'h00, pin}, 8'h01);
        conv(14'h0000, 14'h0000);
        chk("pin", {7'h00, pin}, 8'h00);
        rd(8'h04, 1);
        chk("st", rv[0], 8'h80);
        wr(8'h10, 8'h55);
        chk("ack", {7'h00, ak}, 8'h00);
        wr(8'h00, 8'h55);
        chk("ack", {7'h00, ak}, 8'h00);
        wr(8'h04, 8'hFF);
        chk("ack", {7'h00, ak}, 8'h01);
        rd(8'h00, 5);
        chk("ro", rv[0], 8'h00);
        chk("st", rv[4], 8'h00);
        wr2(8'h08, 8'hA5, 8'h5A);
        chk("ttrim", ttrim, 8'hA5);
        chk("htrim", htrim, 8'h5A);
        wr(8'h0F, 8'h3C);
        chk("setup", setup, 8'h3C);
        wr(8'h0E, 8'h80);
        chk("srst", {7'h00, soft_seen}, 8'h01);
        chk("ttrim", ttrim, 8'h00);
        chk("pin", {7'h00, pin}, 8'h01);
        rd(8'h05, 10);
        chk("soft", rv[0], 8'h00);
        chk("soft", rv[6], 8'h7F);
        chk("soft", rv[9], 8'h00);
        conclude();
    end
    initial begin
        host_u.tk(100000);
        n_mismatch++;
        conclude();
    end
endmodule
